// ### core/dhp_pkg.sv
// Shared constants, state codes and helpers for the dual host port.
// Assumes a single clock domain and a register file outside the port.
package dhp_pkg;

   // ************************************************************
   // Addressing and command codes
   // ************************************************************
   localparam logic [5:0] I2C_ADDR_HI = 6'h35; // Upper six address bits
   localparam logic [7:0] SPI_WR_CMD  = 8'hD4; // Four-wire write command
   localparam logic [7:0] SPI_RD_CMD  = 8'hD5; // Four-wire read command
   localparam logic [7:0] LAST_SUB    = 8'h7F; // Highest register subaddress

   // ************************************************************
   // Reset values and counts
   // ************************************************************
   localparam logic [7:0] PTR_RST    = 8'h00; // Pointer after reset
   localparam logic       PIN_RST    = 1'h1;  // Idle level of every pin
   localparam logic [1:0] SW_EDGES   = 2'h3;  // Select rises that switch mode
   localparam logic [3:0] BIT_LAST   = 4'h7;  // Index of eighth bit
   localparam logic [3:0] BIT_ALL    = 4'h8;  // Bits per byte
   localparam logic [1:0] IDX_SUB    = 2'h1;  // Four-wire subaddress byte
   localparam logic [1:0] IDX_DATA   = 2'h2;  // Four-wire data bytes

   // Two-wire engine states
   typedef enum logic [2:0]
   {
      ST_IDLE  = 3'b000,
      ST_ADDR  = 3'b001,
      ST_SUB   = 3'b010,
      ST_WDATA = 3'b011,
      ST_ACK   = 3'b100,
      ST_RDATA = 3'b101,
      ST_RACK  = 3'b110
   } dhp_i2c_st_t;

   // Subaddress lies inside the register map
   function automatic logic sub_valid(input logic [7:0] s);
      return s <= LAST_SUB;
   endfunction

endpackage

// ### core/dhp_sync.sv
// Two-flop synchroniser with edge detection for the serial pins.
// Assumes asynchronous pin inputs; edges are one-cycle pulses.
`timescale 1ns/1ps
module dhp_sync
#(
   parameter int W = 3
)
(
   input  wire logic         clk,
   input  wire logic         arst_n,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] sync,
   output logic      [W-1:0] rise,
   output logic      [W-1:0] fall
);
   logic [W-1:0] meta; // First stage, seen only by second
   logic [W-1:0] last; // Previous synchronised level

   // ************************************************************
   // Synchroniser chain
   // ************************************************************
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         meta <= {W{dhp_pkg::PIN_RST}};
         sync <= {W{dhp_pkg::PIN_RST}};
         last <= {W{dhp_pkg::PIN_RST}};
      end
      else
      begin
         meta <= din;
         sync <= meta;
         last <= sync;
      end
   end

   // Edge pulses from settled stages only
   assign rise = sync & ~last;
   assign fall = ~sync & last;

endmodule

// ### core/dhp_mode.sv
// Port mode latch: two-wire after reset, four-wire after three select rises.
// Assumes sel_rise is a synchronised one-cycle pulse.
`timescale 1ns/1ps
module dhp_mode
(
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic sel_rise,
   output logic      spi_mode
);
   logic [1:0] edges; // Select rises seen so far

   // ************************************************************
   // Edge counter and sticky mode bit
   // ************************************************************
   // two-wire after reset
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         edges    <= 2'h0;
         spi_mode <= 1'h0;
      end
      else if (!spi_mode && sel_rise)
      begin
         edges <= edges + 2'h1;
         if (edges == dhp_pkg::SW_EDGES - 2'h1)
         begin
            spi_mode <= 1'h1;
         end
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);

   chk_mode_sticky: assert property (spi_mode |=> spi_mode)
      else $error("four-wire mode dropped without reset");
   chk_third_edge: assert property (
      (!spi_mode && sel_rise && edges == 2'h2) |=> spi_mode)
      else $error("third select rise did not switch mode");
   chk_early_switch: assert property (
      (!spi_mode && edges < 2'h2) |=> !spi_mode)
      else $error("mode switched before third select rise");
   cov_switch: cover property (!spi_mode ##1 spi_mode);

endmodule

// ### core/dhp_host_port.sv
// Dual two-wire / four-wire serial host port of the encoder.
// Assumes a 10 MHz CLK, pins from outside, register file on REG_* ports.
`timescale 1ns/1ps

module dhp_host_port
(
   input  wire logic       CLK,
   input  wire logic       ARST_N,
   input  wire logic       SCL_MOSI,
   input  wire logic       SDA_SCLK,
   output logic            SDA_O,
   output logic            SDA_OE_N,
   input  wire logic       ADDR_BIT_OR_SLAVE_SELECT,
   output logic            SHARED_LOCK_OR_MISO_PIN_O,
   output logic            SHARED_LOCK_OR_MISO_PIN_OE_N,
   output logic            SPI_MODE,
   output logic [7:0]      REG_WADDR,
   output logic [7:0]      REG_WDATA,
   output logic            REG_WE,
   output logic [7:0]      REG_RADDR,
   output logic            REG_RE,
   input  wire logic [7:0] REG_RDATA
);
   // ************************************************************
   // Pin synchronisers and mode latch
   // ************************************************************
   logic [2:0] pin_s;     // Settled pin levels
   logic [2:0] pin_r;     // Rising edge pulses
   logic [2:0] pin_f;     // Falling edge pulses
   logic       spi_mode;  // Four-wire mode active

   dhp_sync #(.W(3)) u_sync
   (
      .clk    (CLK),
      .arst_n (ARST_N),
      .din    ({SCL_MOSI, SDA_SCLK, ADDR_BIT_OR_SLAVE_SELECT}),
      .sync   (pin_s),
      .rise   (pin_r),
      .fall   (pin_f)
   );

   dhp_mode u_mode
   (
      .clk      (CLK),
      .arst_n   (ARST_N),
      .sel_rise (pin_r[0]),
      .spi_mode (spi_mode)
   );

   wire scl  = pin_s[2]; // Two-wire clock, also MOSI
   wire sda  = pin_s[1]; // Two-wire data level
   wire sel  = pin_s[0]; // Address bit or slave select

   // ************************************************************
   // Shared pointer and register strobes
   // ************************************************************
   logic [7:0] ptr;       // Subaddress pointer
   logic       ptr_over;  // Pointer ran past top
   wire        at_top = (ptr == dhp_pkg::LAST_SUB);

   dhp_pkg::dhp_i2c_st_t st;    // Two-wire state
   dhp_pkg::dhp_i2c_st_t after; // State after acknowledge
   logic [3:0] cnt;       // Bit counter
   logic [7:0] sh;        // Two-wire shifter
   logic       ack_go;    // Acknowledge this byte
   logic       ack_ph;    // Ninth clock in progress
   logic       rack_ok;   // Master acknowledged read byte
   logic       drv;       // Pull SDA low

   logic [2:0] s_cnt;     // Four-wire bit counter
   logic [7:0] s_sh;      // Four-wire input shifter
   logic [1:0] s_idx;     // Byte index in frame
   logic       s_wcmd;    // Write command received
   logic       s_rd;      // Read command received
   logic [2:0] s_ocnt;    // Output bit counter
   logic [7:0] s_osh;     // Output shifter
   logic       miso;      // MISO level

   // Two-wire bus conditions
   wire i2c_on  = !spi_mode;
   wire i_start = i2c_on && scl && pin_f[1];
   wire i_stop  = i2c_on && scl && pin_r[1];
   wire [7:0] i_byte = {sh[6:0], sda};
   wire i_done = i2c_on && pin_r[2] && !i_start && !i_stop && cnt == dhp_pkg::BIT_LAST
                 && (st == dhp_pkg::ST_ADDR || st == dhp_pkg::ST_SUB
                     || st == dhp_pkg::ST_WDATA);
   wire i_sub   = i_done && st == dhp_pkg::ST_SUB;
   wire i_wr    = i_done && st == dhp_pkg::ST_WDATA && !ptr_over;
   wire i_fetch = i2c_on && pin_f[2]
                  && ((st == dhp_pkg::ST_ACK && ack_ph && ack_go
                       && after == dhp_pkg::ST_RDATA)
                      || (st == dhp_pkg::ST_RACK && rack_ok));
   // address bit one from select pin
   wire match   = (i_byte[7:1] == {dhp_pkg::I2C_ADDR_HI, sel});

   // Four-wire frame conditions
   wire spi_act = spi_mode && !sel;
   wire [7:0] s_byte = {s_sh[6:0], pin_s[2]};
   wire s_done  = spi_act && pin_r[1] && s_cnt == 3'h7;
   wire s_sub   = s_done && s_idx == dhp_pkg::IDX_SUB && s_wcmd;
   wire s_wr    = s_done && s_idx == dhp_pkg::IDX_DATA && s_wcmd && !ptr_over;
   wire s_fetch = spi_act && pin_f[1] && s_rd && s_ocnt == 3'h0;

   wire       sub_ev   = i_sub || s_sub;
   wire [7:0] sub_byte = i_sub ? i_byte : s_byte;

   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         ptr      <= dhp_pkg::PTR_RST;
         ptr_over <= 1'h0;
      end
      else if (sub_ev)
      begin
         ptr_over <= !dhp_pkg::sub_valid(sub_byte);
         if (dhp_pkg::sub_valid(sub_byte))
         begin
            ptr <= sub_byte;
         end
      end
      else if (i_wr || s_wr || i_fetch || s_fetch)
      begin
         if (at_top)
         begin
            ptr_over <= 1'h1;
         end
         else
         begin
            ptr <= ptr + 8'h01;
         end
      end
   end

   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         REG_WE    <= 1'h0;
         REG_WADDR <= dhp_pkg::PTR_RST;
         REG_WDATA <= 8'h00;
      end
      else
      begin
         REG_WE <= i_wr || s_wr;
         if (i_wr || s_wr)
         begin
            REG_WADDR <= ptr;
            REG_WDATA <= i_wr ? i_byte : s_byte;
         end
      end
   end

   assign REG_RADDR = ptr;
   assign REG_RE    = i_fetch || s_fetch;

   // ************************************************************
   // Two-wire slave engine
   // ************************************************************
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         st      <= dhp_pkg::ST_IDLE;
         after   <= dhp_pkg::ST_IDLE;
         cnt     <= 4'h0;
         sh      <= 8'h00;
         ack_go  <= 1'h0;
         ack_ph  <= 1'h0;
         rack_ok <= 1'h0;
         drv     <= 1'h0;
      end
      else if (spi_mode)
      begin
         st  <= dhp_pkg::ST_IDLE;
         drv <= 1'h0;
      end
      else if (i_stop)
      begin
         st  <= dhp_pkg::ST_IDLE;
         drv <= 1'h0;
      end
      else if (i_start)
      begin
         st  <= dhp_pkg::ST_ADDR;
         cnt <= 4'h0;
         drv <= 1'h0;
      end
      else
      begin
         unique case (st)
            dhp_pkg::ST_IDLE:
               st <= dhp_pkg::ST_IDLE;
            dhp_pkg::ST_ADDR, dhp_pkg::ST_SUB, dhp_pkg::ST_WDATA:
               if (i_done)
               begin
                  cnt    <= 4'h0;
                  ack_ph <= 1'h0;
                  st     <= dhp_pkg::ST_ACK;
                  after  <= dhp_pkg::ST_WDATA;
                  if (st == dhp_pkg::ST_ADDR)
                  begin
                     // direction bit picks read or write
                     ack_go <= match;
                     after  <= i_byte[0] ? dhp_pkg::ST_RDATA : dhp_pkg::ST_SUB;
                     if (!match)
                     begin
                        st <= dhp_pkg::ST_IDLE;
                     end
                  end
                  else if (st == dhp_pkg::ST_SUB)
                  begin
                     ack_go <= dhp_pkg::sub_valid(i_byte);
                  end
                  else
                  begin
                     ack_go <= !ptr_over;
                  end
               end
               else if (pin_r[2])
               begin
                  sh  <= i_byte;
                  cnt <= cnt + 4'h1;
               end
            // pull SDA low through ninth clock
            dhp_pkg::ST_ACK:
               if (pin_f[2] && !ack_ph)
               begin
                  drv    <= ack_go;
                  ack_ph <= 1'h1;
               end
               else if (i_fetch)
               begin
                  st  <= dhp_pkg::ST_RDATA;
                  sh  <= REG_RDATA;
                  drv <= !REG_RDATA[7];
                  cnt <= 4'h1;
               end
               else if (pin_f[2])
               begin
                  drv <= 1'h0;
                  st  <= ack_go ? after : dhp_pkg::ST_IDLE;
               end
            dhp_pkg::ST_RDATA:
               if (pin_f[2] && cnt == dhp_pkg::BIT_ALL)
               begin
                  drv     <= 1'h0;
                  rack_ok <= 1'h0;
                  st      <= dhp_pkg::ST_RACK;
               end
               else if (pin_f[2])
               begin
                  drv <= !sh[3'(dhp_pkg::BIT_LAST - cnt)];
                  cnt <= cnt + 4'h1;
               end
            dhp_pkg::ST_RACK:
               if (pin_r[2])
               begin
                  rack_ok <= !sda;
                  if (sda)
                  begin
                     st <= dhp_pkg::ST_IDLE;
                  end
               end
               else if (i_fetch)
               begin
                  st  <= dhp_pkg::ST_RDATA;
                  sh  <= REG_RDATA;
                  drv <= !REG_RDATA[7];
                  cnt <= 4'h1;
               end
            default:
               st <= dhp_pkg::ST_IDLE;
         endcase
      end
   end

   assign SDA_O    = 1'h0;
   assign SDA_OE_N = !drv;

   // ************************************************************
   // Four-wire slave engine
   // ************************************************************
   // frame opens with select low
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         s_cnt  <= 3'h0;
         s_sh   <= 8'h00;
         s_idx  <= 2'h0;
         s_wcmd <= 1'h0;
         s_rd   <= 1'h0;
      end
      else if (!spi_act)
      begin
         s_cnt  <= 3'h0;
         s_idx  <= 2'h0;
         s_wcmd <= 1'h0;
         s_rd   <= 1'h0;
      end
      else if (pin_r[1])
      begin
         s_sh  <= s_byte;
         s_cnt <= s_cnt + 3'h1;
         if (s_done && s_idx == 2'h0)
         begin
            s_wcmd <= (s_byte == dhp_pkg::SPI_WR_CMD);
            s_rd   <= (s_byte == dhp_pkg::SPI_RD_CMD);
         end
         if (s_done && s_idx != dhp_pkg::IDX_DATA)
         begin
            s_idx <= s_idx + 2'h1;
         end
      end
   end

   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         s_ocnt <= 3'h0;
         s_osh  <= 8'h00;
         miso   <= 1'h0;
      end
      else if (!spi_act || !s_rd)
      begin
         s_ocnt <= 3'h0;
      end
      else if (s_fetch)
      begin
         miso   <= REG_RDATA[7];
         s_osh  <= {REG_RDATA[6:0], 1'h0};
         s_ocnt <= 3'h1;
      end
      else if (pin_f[1])
      begin
         miso   <= s_osh[7];
         s_osh  <= {s_osh[6:0], 1'h0};
         s_ocnt <= s_ocnt + 3'h1;
      end
   end

   assign SHARED_LOCK_OR_MISO_PIN_O    = miso;
   assign SHARED_LOCK_OR_MISO_PIN_OE_N = !spi_act;
   assign SPI_MODE                     = spi_mode;

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking @(posedge CLK); endclocking
   default disable iff (!ARST_N);

   chk_sda_drive_own: assert property (
      !SDA_OE_N |-> (st == dhp_pkg::ST_ACK && ack_go) || st == dhp_pkg::ST_RDATA)
      else $error("SDA driven outside acknowledge or read data");
   chk_miso_float: assert property (sel |-> SHARED_LOCK_OR_MISO_PIN_OE_N)
      else $error("MISO driven while deselected");
   chk_stop_idle: assert property (i_stop |=> st == dhp_pkg::ST_IDLE && SDA_OE_N)
      else $error("stop did not return to idle");
   chk_start_addr: assert property (i_start |=> st == dhp_pkg::ST_ADDR && cnt == 4'h0)
      else $error("start did not open address byte");
   chk_bad_sub_nak: assert property (
      (i_sub && !dhp_pkg::sub_valid(i_byte)) |=> !ack_go ##1 SDA_OE_N[*2])
      else $error("invalid subaddress acknowledged");
   chk_overflow_drop: assert property (
      (i_done && st == dhp_pkg::ST_WDATA && ptr_over) |=> !REG_WE && !ack_go)
      else $error("overflow write not discarded");
   chk_top_repeat: assert property ((i_fetch && at_top) |=> at_top)
      else $error("read pointer left highest register");
   chk_write_incr: assert property (
      (i_wr && !at_top) |=> REG_WE && REG_WADDR == $past(ptr) && ptr == $past(ptr) + 8'h01)
      else $error("write did not store and advance pointer");
   chk_foreign_addr: assert property (
      (i_done && st == dhp_pkg::ST_ADDR && !match) |=> st == dhp_pkg::ST_IDLE && SDA_OE_N)
      else $error("foreign address not ignored");

   cov_i2c_write: cover property (i_wr ##1 REG_WE);
   cov_i2c_read_end: cover property (st == dhp_pkg::ST_RACK && pin_r[2] && sda);
   cov_spi_read: cover property (s_fetch);
   cov_spi_write: cover property (s_wr);

endmodule

// ### test/dhp_bus_master.sv
// Host-side bus master model: drives two-wire and four-wire frames.
// Assumes a 10 MHz clk; link phases are whole clk counts (800 ns bit).
`timescale 1ns/1ps
module dhp_bus_master
(
   input  wire logic clk,
   input  wire logic sda_oe_n,
   input  wire logic sda_o,
   input  wire logic miso,
   output logic      scl_mosi,
   output logic      sda_sclk,
   output logic      sel
);
   logic sda_m; // Own SDA drive, 1 = released

   // Open drain with pull-up: low when either side pulls
   assign sda_sclk = sda_m & (sda_oe_n | sda_o);

   // Idle high on every line at release of reset
   initial
   begin
      scl_mosi = 1'h1;
      sda_m    = 1'h1;
      sel      = 1'h1;
   end

   // One phase: set lines on an edge, hold n cycles
   task automatic st(input logic c, input logic d, input int n);
      scl_mosi <= c;
      sda_m    <= d;
      repeat (n) @(posedge clk);
   endtask

   task automatic start();
      st(1'h1, 1'h1, 4);
      st(1'h1, 1'h0, 4);
      st(1'h0, 1'h0, 2);
   endtask

   task automatic stop();
      st(1'h0, 1'h0, 2);
      st(1'h1, 1'h0, 4);
      st(1'h1, 1'h1, 4);
   endtask

   // byte out MSB first, data moves while clock low
   task automatic wr(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--)
      begin
         st(1'h0, b[i], 2);
         st(1'h1, b[i], 4);
         st(1'h0, b[i], 2);
      end
      st(1'h0, 1'h1, 2);
      st(1'h1, 1'h1, 2);
      ack = ~sda_sclk;
      st(1'h1, 1'h1, 2);
      st(1'h0, 1'h1, 2);
   endtask

   // byte in, then acknowledge or leave high
   task automatic rd(input logic nack, output logic [7:0] b);
      for (int i = 7; i >= 0; i--)
      begin
         st(1'h0, 1'h1, 2);
         st(1'h1, 1'h1, 2);
         b[i] = sda_sclk;
         st(1'h1, 1'h1, 2);
         st(1'h0, 1'h1, 2);
      end
      st(1'h0, nack, 2);
      st(1'h1, nack, 4);
      st(1'h0, nack, 2);
   endtask

   // three low pulses on the select pin
   task automatic pulses();
      repeat (3)
      begin
         sel <= 1'h0;
         repeat (4) @(posedge clk);
         sel <= 1'h1;
         repeat (4) @(posedge clk);
      end
   endtask

   // clock parked low, then select low
   task automatic sel_lo();
      st(1'h1, 1'h0, 4);
      sel <= 1'h0;
      repeat (4) @(posedge clk);
   endtask

   // clock low, select raised and held
   task automatic sel_hi();
      st(1'h1, 1'h0, 4);
      sel <= 1'h1;
      repeat (6) @(posedge clk);
   endtask

   // MOSI MSB first, MISO taken at the rise
   task automatic sx(input logic [7:0] o, output logic [7:0] r);
      for (int i = 7; i >= 0; i--)
      begin
         st(o[i], 1'h0, 4);
         r[i] = miso;
         st(o[i], 1'h1, 4);
      end
   endtask
endmodule

// ### test/dhp_host_port_test.sv
// Self-checking bench for the dual host port.
// Assumes the master model drives the pins; register file is a pattern.
`timescale 1ns/1ps
module dhp_host_port_test;
   logic       CLK;
   logic       ARST_N;
   logic       scl_mosi, sda_sclk, sel, sda_o, sda_oe_n;
   logic       miso_o, miso_oe_n, spi_mode, we, re;
   logic [7:0] waddr, wdata, raddr, rdata;
   logic       a;
   logic [7:0] r;
   int         err_count = 0;
   int         total_checks = 0;
   int         re_count = 0; // Register read strobes seen
   logic [15:0] wq[$]; // Captured register writes

   // Register file answers address xor a pattern
   assign rdata = raddr ^ 8'h5A;

   dhp_host_port dut (.CLK(CLK), .ARST_N(ARST_N), .SCL_MOSI(scl_mosi), .SDA_SCLK(sda_sclk),
      .SDA_O(sda_o), .SDA_OE_N(sda_oe_n), .ADDR_BIT_OR_SLAVE_SELECT(sel),
      .SHARED_LOCK_OR_MISO_PIN_O(miso_o), .SHARED_LOCK_OR_MISO_PIN_OE_N(miso_oe_n),
      .SPI_MODE(spi_mode), .REG_WADDR(waddr), .REG_WDATA(wdata), .REG_WE(we),
      .REG_RADDR(raddr), .REG_RE(re), .REG_RDATA(rdata));

   // Floating MISO shows the inverse of the last driven level
   dhp_bus_master m (.clk(CLK), .sda_oe_n(sda_oe_n), .sda_o(sda_o),
      .miso(miso_oe_n ? ~miso_o : miso_o),
      .scl_mosi(scl_mosi), .sda_sclk(sda_sclk), .sel(sel));

   // Clock and write capture
   initial CLK = 1'h0;
   always #50 CLK = ~CLK;
   always @(posedge CLK)
   begin
      if (we === 1'h1)
         wq.push_back({waddr, wdata});
      if (re === 1'h1)
         re_count++;
   end

   task automatic tally_and_finish();
      if (err_count == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string s);
      total_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch at %0t: %s", $time, s);
      end
   endtask

   // Next captured write must match, an empty queue gives X
   task automatic wchk(input logic [7:0] ad, input logic [7:0] d);
      logic [15:0] w;
      w = (wq.size() > 0) ? wq.pop_front() : 16'hXXXX;
      chk(w[15:8], ad, "write address");
      chk(w[7:0], d, "write data");
   endtask

   task automatic do_reset();
      ARST_N <= 1'h0;
      repeat (10) @(posedge CLK);
      ARST_N <= 1'h1;
      repeat (4) @(posedge CLK);
   endtask

   task automatic t_reset();
      chk(spi_mode, 1'h0, "mode after reset");
      chk(sda_oe_n, 1'h1, "sda released");
      chk(sda_o, 1'h0, "sda pulls low");
      chk(miso_oe_n, 1'h1, "miso floats");
   endtask

   task automatic t_write();
      m.start();
      m.wr(8'hD6, a); chk(a, 1'h1, "address ack");
      m.wr(8'h10, a); chk(a, 1'h1, "sub ack");
      m.wr(8'hA5, a); chk(a, 1'h1, "data ack");
      m.wr(8'h3C, a); chk(a, 1'h1, "data ack");
      m.stop();
      wchk(8'h10, 8'hA5);
      wchk(8'h11, 8'h3C);
   endtask

   task automatic t_refuse();
      m.start();
      m.wr(8'hD4, a); chk(a, 1'h0, "foreign address");
      m.wr(8'h20, a); chk(a, 1'h0, "stays idle");
      m.stop();
      m.start();
      m.wr(8'hD6, a); chk(a, 1'h1, "address ack");
      m.wr(8'h80, a); chk(a, 1'h0, "bad sub");
      m.wr(8'h55, a); chk(a, 1'h0, "idle after bad sub");
      m.stop();
      chk(8'(wq.size()), 8'h00, "no writes");
   endtask

   task automatic t_read_top();
      m.start();
      m.wr(8'hD6, a); m.wr(8'h7E, a); chk(a, 1'h1, "sub ack");
      m.stop();
      m.start();
      m.wr(8'hD7, a); chk(a, 1'h1, "read address");
      m.rd(1'h0, r); chk(r, 8'h7E ^ 8'h5A, "read byte");
      m.rd(1'h0, r); chk(r, 8'h7F ^ 8'h5A, "read top");
      m.rd(1'h1, r); chk(r, 8'h7F ^ 8'h5A, "top repeats");
      m.stop();
      chk(8'(re_count), 8'h03, "one fetch per read byte");
   endtask

   task automatic t_write_top();
      m.start();
      m.wr(8'hD6, a); m.wr(8'h7F, a);
      m.wr(8'h99, a); chk(a, 1'h1, "top write");
      m.wr(8'h66, a); chk(a, 1'h0, "past top refused");
      m.stop();
      wchk(8'h7F, 8'h99);
      chk(8'(wq.size()), 8'h00, "past top dropped");
   endtask

   task automatic t_spi();
      m.pulses();
      chk(spi_mode, 1'h1, "four-wire mode");
      m.sel_lo();
      m.sx(8'hD4, r); m.sx(8'h20, r); m.sx(8'h11, r); m.sx(8'h22, r);
      m.sel_hi();
      wchk(8'h20, 8'h11);
      wchk(8'h21, 8'h22);
      chk(miso_oe_n, 1'h1, "miso floats");
      m.sel_lo();
      m.sx(8'hD4, r); m.sx(8'h30, r);
      m.sel_hi();
      m.sel_lo();
      m.sx(8'hD5, r);
      m.sx(8'h00, r); chk(r, 8'h30 ^ 8'h5A, "spi read");
      m.sx(8'h00, r); chk(r, 8'h31 ^ 8'h5A, "spi next");
      chk(miso_oe_n, 1'h0, "miso driven");
      m.sel_hi();
      m.sel_lo();
      m.sx(8'hA0, r);
      m.sx(8'h40, r);
      m.sx(8'h77, r);
      m.sel_hi();
      chk(8'(wq.size()), 8'h00, "unknown command ignored");
      chk(spi_mode, 1'h1, "mode sticky");
      // Lines back to idle high before reset is released
      m.st(1'h1, 1'h1, 4);
      do_reset();
      chk(spi_mode, 1'h0, "mode cleared");
   endtask

   // Watchdog
   initial
   begin
      repeat (30000) @(posedge CLK);
      err_count++;
      tally_and_finish();
   end

   initial
   begin
      ARST_N = 1'h0;
      do_reset();
      t_reset();
      t_write();
      t_refuse();
      t_read_top();
      t_write_top();
      t_spi();
      tally_and_finish();
   end
endmodule
